// File: rtl/cmd_serial_rx.sv
// Asynchronous serial byte receiver for the pulse width command input.
`timescale 1ns/10ps
`default_nettype none
`include "pps_cfg.svh"
module cmd_serial_rx
    import pps_pkg::*;
#(
    parameter int BIT_CYCLES = `PPS_BIT_CYCLES
) (
    input  wire logic       mclk_i,
    input  wire logic       rstn_i,
    input  wire logic       rx_i,
    output logic [7:0]      data_o,
    output logic            valid_o
);
    localparam logic [15:0] BIT_LAST  = 16'(BIT_CYCLES - 1);
    localparam logic [15:0] HALF_LAST = 16'(BIT_CYCLES / 2 - 1);

    rx_regs_t r;
    rx_regs_t next_r;

    always_comb begin
        next_r = r;
        next_r.valid = 1'b0;
        next_r.sync = {r.sync[1:0], rx_i};
        // The line level only changes once the last two stages agree.
        if (r.sync[2] == r.sync[1]) begin
            next_r.level = r.sync[2];
        end
        case (r.state)
            RX_IDLE: begin
                next_r.cnt = 16'h0000;
                if (!r.level) begin
                    next_r.state = RX_START;
                end
            end
            RX_START: begin
                next_r.cnt = r.cnt + 16'h0001;
                if (r.cnt == HALF_LAST) begin
                    next_r.cnt = 16'h0000;
                    next_r.bits = 4'h0;
                    // A glitch shorter than half a bit is dropped here.
                    next_r.state = r.level ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                next_r.cnt = r.cnt + 16'h0001;
                if (r.cnt == BIT_LAST) begin
                    next_r.cnt = 16'h0000;
                    next_r.shift = {r.level, r.shift[7:1]};
                    next_r.bits = r.bits + 4'h1;
                    if (r.bits == `PPS_DATA_BITS - 4'h1) begin
                        next_r.state = RX_STOP;
                    end
                end
            end
            default: begin
                next_r.cnt = r.cnt + 16'h0001;
                if (r.cnt == BIT_LAST) begin
                    next_r.state = RX_IDLE;
                    if (r.level) begin
                        next_r.data = r.shift;
                        next_r.valid = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            r <= '{sync: 3'h7, level: 1'b1, state: RX_IDLE, cnt: 16'h0000,
                   bits: 4'h0, shift: 8'h00, data: 8'h00, valid: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    assign data_o  = r.data;
    assign valid_o = r.valid;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    stop_bit_high_a: assert property (
        valid_o |-> $past(r.level) && $past(r.state) == RX_STOP)
        else $error("Byte accepted without a high stop bit.");
    valid_single_a: assert property (
        valid_o |=> !valid_o)
        else $error("Byte strobe lasted more than one cycle.");
endmodule
`default_nettype wire

// File: rtl/pps_cfg.svh
// Constants for the second pulse generator and its command receiver.
`ifndef PPS_CFG_SVH
`define PPS_CFG_SVH
`define PPS_CLK_NS       20
`define PPS_MS_NS        1000000
`define PPS_MS_CYCLES    (`PPS_MS_NS / `PPS_CLK_NS)
`define PPS_DEF_WIDTH_MS 16'h0064
`define PPS_MAX_WIDTH_MS 16'h03E7
`define PPS_MIN_WIDTH_MS 16'h0001
`define PPS_MIN_SATS     6'h05
`define PPS_BAUD         9600
`define PPS_BIT_NS       (1000000000 / `PPS_BAUD)
`define PPS_BIT_CYCLES   (`PPS_BIT_NS / `PPS_CLK_NS)
`define PPS_CMD_HDR      8'hA5
`define PPS_DATA_BITS    4'h8
`endif

// File: rtl/pps_pkg.sv
// Types shared by the second pulse generator and its command receiver.
`default_nettype none
package pps_pkg;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
    typedef enum logic [1:0] {CMD_HDR, CMD_HI, CMD_LO} cmd_state_t;

    typedef struct packed {
        logic [2:0]  sync;
        logic        level;
        rx_state_t   state;
        logic [15:0] cnt;
        logic [3:0]  bits;
        logic [7:0]  shift;
        logic [7:0]  data;
        logic        valid;
    } rx_regs_t;

    typedef struct packed {
        logic        pulse;
        logic [15:0] pre;
        logic [15:0] ms;
        logic [15:0] width;
        cmd_state_t  cmd;
        logic [7:0]  hi;
    } pps_regs_t;
endpackage
`default_nettype wire

// File: rtl/second_pulse_gen.sv
// Once-per-second timing pulse generator with serial width command.
`timescale 1ns/10ps
`default_nettype none
`include "pps_cfg.svh"
module second_pulse_gen
    import pps_pkg::*;
#(
    parameter int MS_CYCLES  = `PPS_MS_CYCLES,
    parameter int BIT_CYCLES = `PPS_BIT_CYCLES
) (
    input  wire logic       mclk_i,
    input  wire logic       rstn_i,
    input  wire logic       second_tick_i,
    input  wire logic       fix_3d_i,
    input  wire logic [5:0] sats_used_i,
    input  wire logic       cmd_rx_i,
    output logic            second_pulse_out_o
);
    localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

    pps_regs_t   s;
    pps_regs_t   next_s;
    logic [7:0]  rx_data;
    logic        rx_valid;
    logic        enabled;
    logic [15:0] req_width;

    cmd_serial_rx #(
        .BIT_CYCLES (BIT_CYCLES)
    ) u_rx (
        .mclk_i  (mclk_i),
        .rstn_i  (rstn_i),
        .rx_i    (cmd_rx_i),
        .data_o  (rx_data),
        .valid_o (rx_valid)
    );

    // The tick is registered once, so the output edge trails the second by a fixed cycle.
    assign enabled   = fix_3d_i && (sats_used_i >= `PPS_MIN_SATS);
    assign req_width = {s.hi, rx_data};

    always_comb begin
        next_s = s;
        // Width command: header byte, then width in ms, high byte first.
        if (rx_valid) begin
            case (s.cmd)
                CMD_HDR: begin
                    if (rx_data == `PPS_CMD_HDR) begin
                        next_s.cmd = CMD_HI;
                    end
                end
                CMD_HI: begin
                    next_s.hi = rx_data;
                    next_s.cmd = CMD_LO;
                end
                default: begin
                    next_s.cmd = CMD_HDR;
                    // Widths of a second or more are clamped so the line drops first.
                    if (req_width > `PPS_MAX_WIDTH_MS) begin
                        next_s.width = `PPS_MAX_WIDTH_MS;
                    end else if (req_width < `PPS_MIN_WIDTH_MS) begin
                        next_s.width = `PPS_MIN_WIDTH_MS;
                    end else begin
                        next_s.width = req_width;
                    end
                end
            endcase
        end
        if (!enabled) begin
            next_s.pulse = 1'b0;
        end else if (second_tick_i) begin
            next_s.pulse = 1'b1;
            next_s.pre = 16'h0000;
            next_s.ms = 16'h0000;
        end else if (s.pulse) begin
            next_s.pre = s.pre + 16'h0001;
            if (s.pre == MS_LAST) begin
                next_s.pre = 16'h0000;
                next_s.ms = s.ms + 16'h0001;
                if (s.ms + 16'h0001 >= s.width) begin
                    next_s.pulse = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            s <= '{pulse: 1'b0, pre: 16'h0000, ms: 16'h0000,
                   width: `PPS_DEF_WIDTH_MS, cmd: CMD_HDR, hi: 8'h00};
        end else begin
            s <= next_s;
        end
    end

    assign second_pulse_out_o = s.pulse;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    // The parser state carries the earlier bytes, so the header and low-byte steps are watched on their own.
    sequence hdr_byte_s;
        rx_valid && rx_data == `PPS_CMD_HDR && s.cmd == CMD_HDR;
    endsequence

    sequence width_lo_s;
        rx_valid && s.cmd == CMD_LO;
    endsequence

    hdr_takes_a: assert property (
        hdr_byte_s |=> s.cmd == CMD_HI)
        else $error("Header byte did not open a width command.");

    gate_sats_low_a: assert property (
        !enabled |=> !second_pulse_out_o)
        else $error("Pulse present without a sufficient solution.");
    no_fix_low_a: assert property (
        !fix_3d_i [*2] |-> !second_pulse_out_o)
        else $error("Pulse present without a 3D fix.");
    rise_on_tick_a: assert property (
        $rose(second_pulse_out_o) |-> $past(second_tick_i) && $past(enabled))
        else $error("Pulse rose away from the second tick.");
    tick_starts_a: assert property (
        second_tick_i && enabled |=> second_pulse_out_o && s.ms == 16'h0000)
        else $error("Second tick did not start a pulse.");
    default_width_a: assert property (
        $rose(rstn_i) |-> s.width == `PPS_DEF_WIDTH_MS)
        else $error("Width not at its power-up default.");
    hold_width_a: assert property (
        $fell(second_pulse_out_o) && $past(enabled) && !$past(second_tick_i)
        |-> $past(s.ms) + 16'h0001 == $past(s.width))
        else $error("Pulse ended at the wrong width.");
    cmd_applies_a: assert property (
        width_lo_s |=> s.width == (($past(req_width) > `PPS_MAX_WIDTH_MS) ?
            `PPS_MAX_WIDTH_MS : (($past(req_width) < `PPS_MIN_WIDTH_MS) ?
            `PPS_MIN_WIDTH_MS : $past(req_width))))
        else $error("Width command not applied.");
    width_clamped_a: assert property (
        s.width <= `PPS_MAX_WIDTH_MS && s.width >= `PPS_MIN_WIDTH_MS)
        else $error("Width outside one to 999 ms.");
endmodule
`default_nettype wire

// File: testbench/host_uart.sv
// Host model that sends width command bytes on the serial command line.
`timescale 1ns/10ps
`default_nettype none
module host_uart #(
    parameter int BIT_CYCLES = 16
) (
    input  wire logic mclk_i,
    output var logic  tx_o
);
    initial tx_o = 1'b1;
    // The line idles high between frames, so a late start bit is never mistaken for data.
    task automatic send(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge mclk_i);
            tx_o = frame[i];
            repeat (BIT_CYCLES - 1) @(negedge mclk_i);
        end
    endtask
endmodule
`default_nettype wire

// File: testbench/test_second_pulse_gen.sv
// Self-checking bench for the second pulse generator.
`timescale 1ns/10ps
`default_nettype none
module test_second_pulse_gen;
    localparam int MS = 10;
    localparam int BC = 16;
    logic       mclk_i     = 1'b0;
    logic       rstn_i     = 1'b0;
    logic       tick       = 1'b0;
    logic       fix        = 1'b0;
    logic [5:0] sats       = 6'h00;
    wire  logic cmd_rx;
    wire  logic pulse;
    int         num_errors = 0;
    int         cmp_count  = 0;
    int         seed       = 32'h8F16D8EC;
    int         expq[$];
    int         hi_len     = 0;
    int         w;
    int         popped;
    logic       prev_tick  = 1'b0;
    logic       prev_out   = 1'b0;

    second_pulse_gen #(.MS_CYCLES(MS), .BIT_CYCLES(BC)) second_pulse_gen_inst (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .second_tick_i(tick), .fix_3d_i(fix),
        .sats_used_i(sats), .cmd_rx_i(cmd_rx), .second_pulse_out_o(pulse));
    host_uart #(.BIT_CYCLES(BC)) host_uart_inst (.mclk_i(mclk_i), .tx_o(cmd_rx));

    initial begin
        forever #10 mclk_i = ~mclk_i;
    end

    task automatic chk_bit(input logic act, input logic exp);
        cmp_count++;
        if (act !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: level %b, expected %b", $time, act, exp);
        end
    endtask
    task automatic chk_len(input int act, input int exp);
        cmp_count++;
        if (act != exp) begin
            num_errors++;
            $display("MISMATCH at %0t: width %0d, expected %0d", $time, act, exp);
        end
    endtask
    task automatic wrap_up();
        $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // A negative width notes nothing; zero notes a pulse whose length is not judged.
    task automatic fire(input int exp);
        @(negedge mclk_i);
        tick = 1'b1;
        if (exp >= 0) expq.push_back(exp);
        @(negedge mclk_i);
        tick = 1'b0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    task automatic wait_low();
        int i;
        for (i = 0; i < 20000 && pulse !== 1'b0; i++) @(negedge mclk_i);
        if (i == 20000) begin
            num_errors++;
            $display("MISMATCH at %0t: pulse never fell", $time);
            wrap_up();
        end
        idle(50);
    endtask
    task automatic send_width(input logic [15:0] v);
        host_uart_inst.send(8'hA5);
        host_uart_inst.send(v[15:8]);
        host_uart_inst.send(v[7:0]);
        idle(30);
    endtask

    // Watches the output: each rise must follow a tick, each fall closes one noted width.
    always @(posedge mclk_i) begin
        if (pulse === 1'b1) begin
            if (prev_out !== 1'b1) chk_bit(prev_tick, 1'b1);
            hi_len++;
        end else if (prev_out === 1'b1) begin
            if (expq.size() == 0) chk_len(hi_len, -1);
            else begin
                popped = expq.pop_front();
                if (popped > 0) chk_len(hi_len, popped);
            end
            hi_len = 0;
        end
        prev_tick = tick;
        prev_out = pulse;
    end

    initial begin
        idle(4);
        rstn_i = 1'b1;
        idle(5);
        chk_bit(pulse, 1'b0);
        sats = 6'h08;
        fire(-1);
        idle(3);
        chk_bit(pulse, 1'b0);
        fix = 1'b1;
        sats = 6'h04;
        fire(-1);
        idle(3);
        chk_bit(pulse, 1'b0);
        sats = 6'h05;
        fire(100 * MS);
        wait_low();
        host_uart_inst.send(8'h3C);
        send_width(16'h0005);
        fire(5 * MS);
        wait_low();
        send_width(16'h0400);
        fire(999 * MS);
        wait_low();
        send_width(16'h0000);
        fire(1 * MS);
        wait_low();
        for (int k = 0; k < 3; k++) begin
            w = 1 + ({$random(seed)} % 999);
            sats = 6'(5 + ({$random(seed)} % 59));
            send_width(16'(w));
            fire(w * MS);
            wait_low();
        end
        fire(0);
        idle(20);
        fix = 1'b0;
        idle(3);
        chk_bit(pulse, 1'b0);
        idle(5);
        wrap_up();
    end
endmodule
`default_nettype wire
